/* core/pmc_alu.sv */
// Arithmetic unit with standard flag effects
`timescale 1ns/1ps
`default_nettype none
`include "pmc_map.svh"
module pmc_alu
	import pmc_pkg::*;
(
	// Operands
	input  wire logic [3:0] op_hi_i,
	input  wire logic [7:0] acc_i,
	input  wire logic [7:0] opnd_i,
	input  wire logic [7:0] flags_i,
	// Results
	output logic      [7:0] res_o,
	output logic      [7:0] flags_o
);
	logic [8:0] sum;
	logic [4:0] half;
	logic       cin;
	always_comb begin
		cin     = flags_i[`PMC_FLAG_CY];
		res_o   = acc_i;
		flags_o = flags_i;
		sum     = 9'h000;
		half    = 5'h00;
		case (op_hi_i)
		`PMC_OP_ADD, `PMC_OP_ADD_CY: begin
			if (op_hi_i == `PMC_OP_ADD)
				cin = 1'b0;
			sum  = {1'b0, acc_i} + {1'b0, opnd_i} + {8'h00, cin};
			half = {1'b0, acc_i[3:0]} + {1'b0, opnd_i[3:0]} + {4'h0, cin};
			res_o = sum[7:0];
			flags_o[`PMC_FLAG_CY] = sum[8];
			flags_o[`PMC_FLAG_AC] = half[4];
			flags_o[`PMC_FLAG_OV] = (acc_i[7] == opnd_i[7]) && (sum[7] != acc_i[7]);
		end
		`PMC_OP_SUB_BR: begin
			sum  = {1'b0, acc_i} - {1'b0, opnd_i} - {8'h00, cin};
			half = {1'b0, acc_i[3:0]} - {1'b0, opnd_i[3:0]} - {4'h0, cin};
			res_o = sum[7:0];
			flags_o[`PMC_FLAG_CY] = sum[8];
			flags_o[`PMC_FLAG_AC] = half[4];
			flags_o[`PMC_FLAG_OV] = (acc_i[7] != opnd_i[7]) && (sum[7] != acc_i[7]);
		end
		`PMC_OP_INC: res_o = opnd_i + 8'h01;
		`PMC_OP_DEC: res_o = opnd_i - 8'h01;
		default: res_o = acc_i;
		endcase
	end
endmodule // pmc_alu
`default_nettype wire

/* core/pmc_core.sv */
// Instruction timing decoder, arithmetic execution, flash access and debug control
`timescale 1ns/1ps
`default_nettype none
`include "pmc_map.svh"
module pmc_core
	import pmc_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rstn_i,
	// Instruction stream
	input  wire logic [7:0]  opcode_i,
	input  wire logic [7:0]  operand_i,
	input  wire logic        cond_i,
	input  wire logic        issue_i,
	output logic             ready_o,
	// Flash and external data space
	input  wire logic        flash_sel_i,
	input  wire logic        flash_erase_i,
	output logic             flash_wr_o,
	output logic             flash_erase_o,
	output logic             code_rd_o,
	output logic             ext_rd_o,
	output logic             ext_wr_o,
	// Debug link requests
	input  wire logic        dbg_halt_i,
	input  wire logic        dbg_run_i,
	input  wire logic        dbg_step_i,
	input  wire logic        dbg_bp_en_i,
	input  wire logic [15:0] dbg_bp_addr_i,
	input  wire logic        dbg_ram_wr_i,
	input  wire logic [7:0]  dbg_addr_i,
	input  wire logic [7:0]  dbg_wdata_i,
	output logic      [7:0]  dbg_rdata_o,
	output logic             dbg_halted_o,
	// Execution state
	output logic      [3:0]  cycles_o,
	output logic      [1:0]  bytes_o,
	output logic             done_o,
	output logic      [7:0]  acc_o,
	output logic      [7:0]  flags_o,
	output logic      [15:0] pc_o
);
	logic [7:0]    ram_r [0:`PMC_RAM_DEPTH-1];
	logic [7:0]    acc_r, acc_nxt, flags_r, flags_nxt;
	logic [15:0]   pc_r, pc_nxt;
	logic [3:0]    cnt_r, cnt_nxt, cyc;
	logic [1:0]    nbytes;
	pmc_state_type st_r, st_nxt;
	pmc_amode_type am;
	logic [7:0]    opnd, alu_res, alu_flags, ram_addr, dbg_rdata_r, dbg_rdata_nxt;
	logic          busy, accept, halted_req, wr_ram, wr_acc;
	logic [2:0]    halt_s_r, run_s_r, step_s_r;
	logic          halt_q, run_q, step_q;

	// Addressing mode from the low opcode nibble; for nibble 4 the high nibble chooses accumulator or immediate
	function automatic pmc_amode_type amode(input logic [7:0] op);
		// Multiply and divide share the immediate nibble but carry no operand byte
		if (op == `PMC_OP_MUL || op == `PMC_OP_DIV)
			amode = PMC_AM_NONE;
		else if (op[3])
			amode = PMC_AM_REG;
		else if (op[3:1] == 3'b011)
			amode = PMC_AM_IND;
		else if (op[3:0] == 4'h5)
			amode = PMC_AM_DIR;
		else if (op[3:0] == 4'h4)
			amode = (op[7:4] <= `PMC_OP_DEC) ? PMC_AM_ACC : PMC_AM_IMM;
		else
			amode = PMC_AM_NONE;
	endfunction

	// Cycle count for one instruction
	function automatic logic [3:0] clocks(input logic [7:0] op, input logic taken);
		case (op)
		`PMC_OP_JC, `PMC_OP_JNC:
			clocks = taken ? 4'h3 : 4'h2;
		`PMC_OP_JB, `PMC_OP_JNB, `PMC_OP_JBC:
			clocks = taken ? 4'h4 : 4'h3;
		`PMC_OP_XMV_RD_DP, `PMC_OP_XMV_RD_RI0, `PMC_OP_XMV_RD_RI1,
		`PMC_OP_XMV_WR_DP, `PMC_OP_XMV_WR_RI0, `PMC_OP_XMV_WR_RI1:
			clocks = `PMC_XMV_CYC;
		`PMC_OP_CMV_DP, `PMC_OP_CMV_PC:
			clocks = `PMC_CMV_CYC;
		`PMC_OP_MUL:
			clocks = `PMC_MUL_CYC;
		`PMC_OP_DIV:
			clocks = `PMC_DIV_CYC;
		default:
			case (amode(op))
			PMC_AM_REG, PMC_AM_ACC: clocks = 4'h1;
			PMC_AM_DIR, PMC_AM_IMM: clocks = 4'h2;
			PMC_AM_IND: clocks = 4'h2;
			default:    clocks = 4'h1;
			endcase
		endcase
	endfunction

	// Program bytes for one instruction
	function automatic logic [1:0] prog_bytes(input logic [7:0] op);
		case (op)
		`PMC_OP_JC, `PMC_OP_JNC:                  prog_bytes = 2'h2;
		`PMC_OP_JB, `PMC_OP_JNB, `PMC_OP_JBC:     prog_bytes = 2'h3;
		default:
			case (amode(op))
			PMC_AM_DIR, PMC_AM_IMM: prog_bytes = 2'h2;
			default:                prog_bytes = 2'h1;
			endcase
		endcase
	endfunction

	// Debug requests come over the link, so they are synchronised
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			halt_s_r <= 3'h0;
			run_s_r  <= 3'h0;
			step_s_r <= 3'h0;
		end else begin
			halt_s_r <= {halt_s_r[1:0], dbg_halt_i};
			run_s_r  <= {run_s_r[1:0], dbg_run_i};
			step_s_r <= {step_s_r[1:0], dbg_step_i};
		end
	end
	assign halt_q = halt_s_r[1];
	assign run_q  = run_s_r[1];
	assign step_q = step_s_r[1] && !step_s_r[2];

	pmc_alu u_alu (
		.op_hi_i (opcode_i[7:4]),
		.acc_i   (acc_r),
		.opnd_i  (opnd),
		.flags_i (flags_r),
		.res_o   (alu_res),
		.flags_o (alu_flags)
	);

	always_comb begin
		am       = amode(opcode_i);
		cyc      = clocks(opcode_i, cond_i);
		nbytes   = prog_bytes(opcode_i);
		ram_addr = (am == PMC_AM_REG) ? {5'h00, opcode_i[2:0]} :
		           (am == PMC_AM_IND) ? ram_r[{7'h00, opcode_i[0]}] : operand_i;
		case (am)
		PMC_AM_IMM: opnd = operand_i;
		PMC_AM_ACC: opnd = acc_r;
		PMC_AM_NONE: opnd = 8'h00;
		default:    opnd = ram_r[ram_addr];
		endcase
	end

	// Halted core takes no new instruction; breakpoint stops before issue
	assign busy       = (cnt_r != 4'h0);
	assign halted_req = dbg_bp_en_i && (pc_r == dbg_bp_addr_i);
	assign ready_o    = !busy && (st_r != PMC_ST_HALT) && !halted_req;
	assign accept     = issue_i && ready_o;
	assign wr_acc     = accept && ((opcode_i[7:4] == `PMC_OP_ADD) ||
	                    (opcode_i[7:4] == `PMC_OP_ADD_CY) || (opcode_i[7:4] == `PMC_OP_SUB_BR) ||
	                    (am == PMC_AM_ACC)) && (am != PMC_AM_NONE);
	assign wr_ram     = accept && !wr_acc && (am != PMC_AM_NONE) && (am != PMC_AM_IMM) &&
	                    ((opcode_i[7:4] == `PMC_OP_INC) || (opcode_i[7:4] == `PMC_OP_DEC));

	always_comb begin
		cnt_nxt = busy ? cnt_r - 4'h1 : 4'h0;
		acc_nxt = acc_r;
		flags_nxt = flags_r;
		pc_nxt  = pc_r;
		st_nxt  = st_r;
		dbg_rdata_nxt = ram_r[dbg_addr_i];
		if (accept) begin
			cnt_nxt = cyc - 4'h1;
			pc_nxt  = pc_r + {14'h0000, nbytes};
			if (wr_acc) begin
				acc_nxt = alu_res;
				flags_nxt = alu_flags;
			end
			if (st_r == PMC_ST_STEP)
				st_nxt = PMC_ST_HALT;
		end
		case (st_r)
		PMC_ST_RUN:  if (halt_q || (halted_req && !busy)) st_nxt = PMC_ST_HALT;
		PMC_ST_HALT: if (step_q) st_nxt = PMC_ST_STEP;
		             else if (run_q) st_nxt = PMC_ST_RUN;
		PMC_ST_STEP: ;
		default:     st_nxt = PMC_ST_HALT;
		endcase
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_r       <= 4'h0;
			acc_r       <= 8'h00;
			flags_r     <= 8'h00;
			pc_r        <= 16'h0000;
			st_r        <= PMC_ST_RUN;
			dbg_rdata_r <= 8'h00;
		end else begin
			cnt_r       <= cnt_nxt;
			acc_r       <= acc_nxt;
			flags_r     <= flags_nxt;
			pc_r        <= pc_nxt;
			st_r        <= st_nxt;
			dbg_rdata_r <= dbg_rdata_nxt;
		end
	end

	// RAM has no reset; debug writes only while halted
	always_ff @(posedge clk_i) begin
		if (wr_ram)
			ram_r[ram_addr] <= alu_res;
		else if (dbg_ram_wr_i && st_r == PMC_ST_HALT)
			ram_r[dbg_addr_i] <= dbg_wdata_i;
	end

	// Flash writes ride on external-data moves when flash is selected
	always_comb begin
		ext_wr_o      = accept && (opcode_i == `PMC_OP_XMV_WR_DP ||
		                opcode_i == `PMC_OP_XMV_WR_RI0 || opcode_i == `PMC_OP_XMV_WR_RI1);
		ext_rd_o      = accept && (opcode_i == `PMC_OP_XMV_RD_DP ||
		                opcode_i == `PMC_OP_XMV_RD_RI0 || opcode_i == `PMC_OP_XMV_RD_RI1);
		flash_wr_o    = ext_wr_o && flash_sel_i && !flash_erase_i;
		flash_erase_o = ext_wr_o && flash_sel_i && flash_erase_i;
		code_rd_o     = accept && (opcode_i == `PMC_OP_CMV_DP ||
		                opcode_i == `PMC_OP_CMV_PC);
	end

	assign cycles_o     = cyc;
	assign bytes_o      = nbytes;
	assign done_o       = (cnt_r == 4'h1) || (accept && cyc == 4'h1);
	assign acc_o        = acc_r;
	assign flags_o      = flags_r;
	assign pc_o         = pc_r;
	assign dbg_rdata_o  = dbg_rdata_r;
	assign dbg_halted_o = (st_r == PMC_ST_HALT);

	property p_max_cycles;
		@(posedge clk_i) disable iff (!rstn_i) cnt_r < `PMC_MAX_CYCLES;
	endproperty
	a_max_cycles: assert property (p_max_cycles) else $error("busy over eight");

	sequence s_take_one;
		accept && cyc == 4'h1;
	endsequence
	property p_single;
		@(posedge clk_i) disable iff (!rstn_i) s_take_one |=> !busy;
	endproperty
	a_single: assert property (p_single) else $error("one clock op stalled");

	// Taken branch stays busy one clock longer than the untaken one
	sequence s_hold_one;
		busy ##1 !busy;
	endsequence
	sequence s_hold_two;
		busy [*2] ##1 !busy;
	endsequence
	property p_branch;
		@(posedge clk_i) disable iff (!rstn_i)
		(accept && opcode_i == `PMC_OP_JC && cond_i) |=> s_hold_two;
	endproperty
	a_branch: assert property (p_branch) else $error("taken branch length");

	property p_branch_nt;
		@(posedge clk_i) disable iff (!rstn_i)
		(accept && opcode_i == `PMC_OP_JC && !cond_i) |=> s_hold_one;
	endproperty
	a_branch_nt: assert property (p_branch_nt) else $error("untaken branch length");

	property p_busy_len;
		@(posedge clk_i) disable iff (!rstn_i)
		(accept && cyc == 4'h2) |=> busy ##1 !busy;
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("two clock op length");

	property p_regop;
		@(posedge clk_i) disable iff (!rstn_i)
		(am == PMC_AM_REG && opcode_i[7:4] == `PMC_OP_ADD) |-> (cyc == 4'h1 && nbytes == 2'h1);
	endproperty
	a_regop: assert property (p_regop) else $error("register op timing");

	property p_indop;
		@(posedge clk_i) disable iff (!rstn_i)
		(am == PMC_AM_IND && opcode_i[7:4] == `PMC_OP_SUB_BR) |-> (cyc == 4'h2 && nbytes == 2'h1);
	endproperty
	a_indop: assert property (p_indop) else $error("indirect op timing");

	property p_immop;
		@(posedge clk_i) disable iff (!rstn_i)
		(am == PMC_AM_IMM) |-> (cyc == 4'h2 && nbytes == 2'h2);
	endproperty
	a_immop: assert property (p_immop) else $error("immediate op timing");

	property p_flash;
		@(posedge clk_i) disable iff (!rstn_i) flash_wr_o |-> (ext_wr_o && !flash_erase_o);
	endproperty
	a_flash: assert property (p_flash) else $error("flash write not via move");

	property p_halt;
		@(posedge clk_i) disable iff (!rstn_i) dbg_halted_o |-> !ready_o;
	endproperty
	a_halt: assert property (p_halt) else $error("issue while halted");
endmodule // pmc_core
`default_nettype wire

/* core/pmc_map.svh */
// Constant map for the multi-cycle core timing decoder
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH
`define PMC_MAX_CYCLES      4'h8
`define PMC_RAM_DEPTH       256
`define PMC_CLK_NS          50
`define PMC_OP_ADD          4'h2
`define PMC_OP_ADD_CY       4'h3
`define PMC_OP_SUB_BR       4'h9
`define PMC_OP_INC          4'h0
`define PMC_OP_DEC          4'h1
`define PMC_OP_XMV_RD_DP    8'hE0
`define PMC_OP_XMV_RD_RI0   8'hE2
`define PMC_OP_XMV_RD_RI1   8'hE3
`define PMC_OP_XMV_WR_DP    8'hF0
`define PMC_OP_XMV_WR_RI0   8'hF2
`define PMC_OP_XMV_WR_RI1   8'hF3
`define PMC_OP_CMV_DP       8'h93
`define PMC_OP_CMV_PC       8'h83
`define PMC_OP_JC           8'h40
`define PMC_OP_JNC          8'h50
`define PMC_OP_JB           8'h20
`define PMC_OP_JNB          8'h30
`define PMC_OP_JBC          8'h10
`define PMC_OP_MUL          8'hA4
`define PMC_OP_DIV          8'h84
`define PMC_XMV_CYC         4'h3
`define PMC_CMV_CYC         4'h3
`define PMC_MUL_CYC         4'h4
`define PMC_DIV_CYC         4'h8
`define PMC_FLAG_CY         7
`define PMC_FLAG_AC         6
`define PMC_FLAG_OV         2
`endif

/* core/pmc_pkg.sv */
// Types shared by the core timing decoder
package pmc_pkg;
	typedef enum logic [2:0] {
		PMC_AM_NONE = 3'b000,
		PMC_AM_REG  = 3'b001,
		PMC_AM_DIR  = 3'b010,
		PMC_AM_IND  = 3'b011,
		PMC_AM_IMM  = 3'b100,
		PMC_AM_ACC  = 3'b101
	} pmc_amode_type;
	typedef enum logic [1:0] {
		PMC_ST_RUN  = 2'b00,
		PMC_ST_HALT = 2'b01,
		PMC_ST_STEP = 2'b10
	} pmc_state_type;
endpackage

/* testbench/pmc_flash_model.sv */
// Flash and external data space model counting accepted accesses
`timescale 1ns/1ps
`default_nettype none
module pmc_flash_model (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rstn_i,
	// Access strobes from the core
	input  wire logic       flash_wr_i,
	input  wire logic       flash_erase_i,
	input  wire logic       code_rd_i,
	input  wire logic       ext_rd_i,
	input  wire logic       ext_wr_i,
	// Access counts
	output logic      [7:0] n_fwr_o,
	output logic      [7:0] n_fer_o,
	output logic      [7:0] n_crd_o,
	output logic      [7:0] n_xrd_o,
	output logic      [7:0] n_xwr_o
);
	// Strobes sampled on the edge that accepts them
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			{n_fwr_o, n_fer_o, n_crd_o, n_xrd_o, n_xwr_o} <= 40'h0;
		end else begin
			n_fwr_o <= n_fwr_o + {7'h0, flash_wr_i === 1'b1};
			n_fer_o <= n_fer_o + {7'h0, flash_erase_i === 1'b1};
			n_crd_o <= n_crd_o + {7'h0, code_rd_i === 1'b1};
			n_xrd_o <= n_xrd_o + {7'h0, ext_rd_i === 1'b1};
			n_xwr_o <= n_xwr_o + {7'h0, ext_wr_i === 1'b1};
		end
	end
endmodule // pmc_flash_model
`default_nettype wire

/* testbench/tb.sv */
// Self-checking bench for the core timing decoder
`timescale 1ns/1ps
`default_nettype none
module tb;
	import pmc_pkg::*;
	logic        clk_i = 1'b0;
	logic        rstn_i = 1'b0;
	logic [7:0]  opcode_i = 8'h00;
	logic [7:0]  operand_i = 8'h00;
	logic        cond_i = 1'b0;
	logic        issue_i = 1'b0;
	logic        flash_sel_i = 1'b0;
	logic        flash_erase_i = 1'b0;
	logic        dbg_halt_i = 1'b0;
	logic        dbg_run_i = 1'b0;
	logic        dbg_step_i = 1'b0;
	logic        dbg_bp_en_i = 1'b0;
	logic [15:0] dbg_bp_addr_i = 16'h0000;
	logic        dbg_ram_wr_i = 1'b0;
	logic [7:0]  dbg_addr_i = 8'h00;
	logic [7:0]  dbg_wdata_i = 8'h00;
	logic [7:0]  dbg_rdata_o, acc_o, flags_o, n_fwr, n_fer, n_crd, n_xrd, n_xwr;
	logic        ready_o, flash_wr_o, flash_erase_o, code_rd_o, ext_rd_o, ext_wr_o;
	logic        dbg_halted_o, done_o;
	logic [3:0]  cycles_o;
	logic [1:0]  bytes_o;
	logic [15:0] pc_o;
	int          n_mismatch = 0;
	int          total_checks = 0;
	int          k;
	logic [7:0]  aop [12] = '{8'h28, 8'h25, 8'h26, 8'h24, 8'h38, 8'h35, 8'h36, 8'h34,
		8'h98, 8'h95, 8'h96, 8'h94};

	always #25 clk_i = ~clk_i;

	pmc_core u_pmc_core (.clk_i(clk_i), .rstn_i(rstn_i), .opcode_i(opcode_i),
		.operand_i(operand_i), .cond_i(cond_i), .issue_i(issue_i), .ready_o(ready_o),
		.flash_sel_i(flash_sel_i), .flash_erase_i(flash_erase_i), .flash_wr_o(flash_wr_o),
		.flash_erase_o(flash_erase_o), .code_rd_o(code_rd_o), .ext_rd_o(ext_rd_o),
		.ext_wr_o(ext_wr_o), .dbg_halt_i(dbg_halt_i), .dbg_run_i(dbg_run_i),
		.dbg_step_i(dbg_step_i), .dbg_bp_en_i(dbg_bp_en_i), .dbg_bp_addr_i(dbg_bp_addr_i),
		.dbg_ram_wr_i(dbg_ram_wr_i), .dbg_addr_i(dbg_addr_i), .dbg_wdata_i(dbg_wdata_i),
		.dbg_rdata_o(dbg_rdata_o), .dbg_halted_o(dbg_halted_o), .cycles_o(cycles_o),
		.bytes_o(bytes_o), .done_o(done_o), .acc_o(acc_o), .flags_o(flags_o), .pc_o(pc_o));

	pmc_flash_model u_pmc_flash_model (.clk_i(clk_i), .rstn_i(rstn_i),
		.flash_wr_i(flash_wr_o), .flash_erase_i(flash_erase_o), .code_rd_i(code_rd_o),
		.ext_rd_i(ext_rd_o), .ext_wr_i(ext_wr_o), .n_fwr_o(n_fwr), .n_fer_o(n_fer),
		.n_crd_o(n_crd), .n_xrd_o(n_xrd), .n_xwr_o(n_xwr));

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic final_report();
		$display("mismatches %0d checks %0d", n_mismatch, total_checks);
		if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	// A wait that used up its bound ends the run as a failure
	task automatic give_up(input int n, input int lim);
		if (n >= lim) begin
			n_mismatch++;
			final_report();
		end
	endtask

	// Offers one instruction, measures clocks until ready again
	task automatic run(input logic [7:0] op, input logic [7:0] opd, input logic cnd,
		input logic [3:0] ec, input logic [1:0] eb, input logic pcchk);
		int n;
		logic [15:0] pc0;
		@(negedge clk_i);
		opcode_i = op;
		operand_i = opd;
		cond_i = cnd;
		issue_i = 1'b1;
		pc0 = pc_o;
		#1;
		chk("ready", 16'h1, {15'h0, ready_o});
		chk("cycles", {12'h0, ec}, {12'h0, cycles_o});
		chk("bytes", {14'h0, eb}, {14'h0, bytes_o});
		chk("done", {15'h0, ec == 4'h1}, {15'h0, done_o});
		@(negedge clk_i);
		issue_i = 1'b0;
		n = 1;
		while (ready_o !== 1'b1 && n < 20) begin
			@(negedge clk_i);
			n++;
		end
		give_up(n, 20);
		chk("clocks", {12'h0, ec}, n[15:0]);
		if (pcchk) chk("pc", pc0 + {14'h0, eb}, pc_o);
	endtask

	task automatic flags_scn();
		run(8'h24, 8'h7F, 1'b0, 4'h2, 2'h2, 1'b1);
		chk("acc", 16'h007F, {8'h0, acc_o});
		run(8'h24, 8'h01, 1'b0, 4'h2, 2'h2, 1'b1);
		chk("flags", 16'h0044, {8'h0, flags_o & 8'hC4});
		run(8'h34, 8'hFF, 1'b0, 4'h2, 2'h2, 1'b1);
		chk("flags", 16'h0084, {8'h0, flags_o & 8'hC4});
		run(8'h94, 8'h00, 1'b0, 4'h2, 2'h2, 1'b1);
		chk("acc", 16'h007E, {8'h0, acc_o});
		chk("flags", 16'h0000, {8'h0, flags_o & 8'hC4});
	endtask

	// Three single-clock increments on three consecutive edges
	task automatic peak_scn();
		@(negedge clk_i);
		opcode_i = 8'h04;
		issue_i = 1'b1;
		repeat (3) @(negedge clk_i);
		issue_i = 1'b0;
		chk("acc", 16'h0081, {8'h0, acc_o});
	endtask

	task automatic debug_scn();
		int n;
		dbg_halt_i = 1'b1;
		n = 0;
		while (dbg_halted_o !== 1'b1 && n < 6) begin
			@(negedge clk_i);
			n++;
		end
		give_up(n, 6);
		chk("halted", 16'h1, {15'h0, dbg_halted_o});
		chk("ready", 16'h0, {15'h0, ready_o});
		dbg_addr_i = 8'h30;
		dbg_wdata_i = 8'hA5;
		dbg_ram_wr_i = 1'b1;
		@(negedge clk_i);
		dbg_ram_wr_i = 1'b0;
		repeat (2) @(negedge clk_i);
		chk("rdata", 16'h00A5, {8'h0, dbg_rdata_o});
		opcode_i = 8'h04;
		issue_i = 1'b1;
		dbg_step_i = 1'b1;
		repeat (8) @(negedge clk_i);
		issue_i = 1'b0;
		dbg_step_i = 1'b0;
		chk("acc", 16'h0082, {8'h0, acc_o});
		chk("halted", 16'h1, {15'h0, dbg_halted_o});
		dbg_halt_i = 1'b0;
		dbg_run_i = 1'b1;
		n = 0;
		while (ready_o !== 1'b1 && n < 8) begin
			@(negedge clk_i);
			n++;
		end
		dbg_run_i = 1'b0;
		give_up(n, 8);
		chk("ready", 16'h1, {15'h0, ready_o});
		dbg_bp_addr_i = pc_o;
		dbg_bp_en_i = 1'b1;
		#1;
		chk("ready", 16'h0, {15'h0, ready_o});
		@(negedge clk_i);
		chk("halted", 16'h1, {15'h0, dbg_halted_o});
		// Breakpoint leaves the core halted; resume before the next scenario
		dbg_bp_en_i = 1'b0;
		dbg_run_i = 1'b1;
		n = 0;
		while (ready_o !== 1'b1 && n < 8) begin
			@(negedge clk_i);
			n++;
		end
		dbg_run_i = 1'b0;
		give_up(n, 8);
		chk("ready", 16'h1, {15'h0, ready_o});
	endtask

	task automatic flash_scn();
		flash_sel_i = 1'b1;
		run(8'hF0, 8'h00, 1'b0, 4'h3, 2'h1, 1'b1);
		flash_erase_i = 1'b1;
		run(8'hF2, 8'h00, 1'b0, 4'h3, 2'h1, 1'b1);
		flash_sel_i = 1'b0;
		flash_erase_i = 1'b0;
		run(8'hF3, 8'h00, 1'b0, 4'h3, 2'h1, 1'b1);
		run(8'hE0, 8'h00, 1'b0, 4'h3, 2'h1, 1'b1);
		run(8'h93, 8'h00, 1'b0, 4'h3, 2'h1, 1'b1);
		chk("flash writes", 16'h1, {8'h0, n_fwr});
		chk("flash erases", 16'h1, {8'h0, n_fer});
		chk("ext writes", 16'h3, {8'h0, n_xwr});
		chk("ext reads", 16'h1, {8'h0, n_xrd});
		chk("code reads", 16'h1, {8'h0, n_crd});
	endtask

	task automatic arith_scn();
		for (k = 0; k < 12; k++) begin
			if (aop[k][3]) run(aop[k], 8'h40, 1'b0, 4'h1, 2'h1, 1'b1);
			else if (aop[k][1]) run(aop[k], 8'h40, 1'b0, 4'h2, 2'h1, 1'b1);
			else run(aop[k], 8'h40, 1'b0, 4'h2, 2'h2, 1'b1);
		end
		run(8'h04, 8'h00, 1'b0, 4'h1, 2'h1, 1'b1);
		run(8'h14, 8'h00, 1'b0, 4'h1, 2'h1, 1'b1);
		run(8'h08, 8'h00, 1'b0, 4'h1, 2'h1, 1'b1);
		run(8'h18, 8'h00, 1'b0, 4'h1, 2'h1, 1'b1);
		run(8'h05, 8'h40, 1'b0, 4'h2, 2'h2, 1'b1);
		run(8'h06, 8'h00, 1'b0, 4'h2, 2'h1, 1'b1);
	endtask

	task automatic branch_scn();
		run(8'h40, 8'h00, 1'b1, 4'h3, 2'h2, 1'b0);
		run(8'h40, 8'h00, 1'b0, 4'h2, 2'h2, 1'b0);
		run(8'h50, 8'h00, 1'b1, 4'h3, 2'h2, 1'b0);
		run(8'h20, 8'h00, 1'b1, 4'h4, 2'h3, 1'b0);
		run(8'h10, 8'h00, 1'b0, 4'h3, 2'h3, 1'b0);
		run(8'hA4, 8'h00, 1'b0, 4'h4, 2'h1, 1'b0);
		run(8'h84, 8'h00, 1'b0, 4'h8, 2'h1, 1'b0);
	endtask

	initial begin
		#(50 * 20000);
		n_mismatch++;
		final_report();
	end

	initial begin
		repeat (8) @(negedge clk_i);
		rstn_i = 1'b1;
		flags_scn();
		peak_scn();
		debug_scn();
		flash_scn();
		arith_scn();
		branch_scn();
		final_report();
	end
endmodule // tb
`default_nettype wire
